// *** hdl/fscs_flash_timer.sv ***
// flash write busy interval
`timescale 1ns/1ps
`include "fscs_regs.svh"
module fscs_flash_timer #(
  parameter int CYC = 140000
) (
  // clock and reset
  input wire logic  ref_clk,
  input wire logic  arst_n,
  // request and status
  input wire logic  start,
  output logic      busy,
  output logic      done
);
  logic [`FSCS_FCNT_W-1:0] cnt_reg;
  logic [`FSCS_FCNT_W-1:0] runLen;
  logic                    last;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  assign last = busy && (cnt_reg == `FSCS_FCNT_W'(CYC - 1));

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg <= '0;
      busy    <= 1'b0;
      done    <= 1'b0;
    end else begin
      done <= last;
      if (start && !busy) begin
        busy    <= 1'b1;
        cnt_reg <= '0;
      end else if (last) begin
        busy <= 1'b0;
      end else if (busy) begin
        cnt_reg <= cnt_reg + 1'b1;
      end
    end
  end

  // helper: length of the current busy run
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      runLen <= '0;
    end else begin
      runLen <= busy ? runLen + 1'b1 : '0;
    end
  end

  AST_FLASH_MAX: assert property (runLen <= `FSCS_FCNT_W'(CYC))
    else $error("flash busy too long");
  AST_DONE_END: assert property (done |-> !busy && $past(busy))
    else $error("done without busy end");
endmodule : fscs_flash_timer

// *** hdl/fscs_pkg.sv ***
// shared types of the snapshot capture store
package fscs_pkg;
  typedef enum logic [0:0] {ST_INIT, ST_RUN} fscs_state_e;
  typedef logic [31:0]  fscs_word_t;
  typedef logic [255:0] fscs_rec_t;
endpackage : fscs_pkg

// *** hdl/fscs_regs.svh ***
// register offsets, field positions and timing counts of the snapshot store
`ifndef FSCS_REGS_SVH
`define FSCS_REGS_SVH
`define FSCS_A_OPTIONS 8'h00
`define FSCS_A_OPER    8'h04
`define FSCS_A_SNAPCMD 8'h08
`define FSCS_A_STATUS  8'h0C
`define FSCS_A_INTST   8'h10
`define FSCS_A_INTMSK  8'h14
`define FSCS_A_FLTCFG  8'h18
`define FSCS_A_CFGCMD  8'h1C
`define FSCS_A_CFGLIVE 8'h20
`define FSCS_SNAP_WIN  3'h2
`define FSCS_B_OUTEN   0
`define FSCS_B_SNAPEN  1
`define FSCS_CMD_LOAD  8'h01
`define FSCS_CMD_SAVE  8'h02
`define FSCS_CFG_DEF   8'h01
`define FSCS_CFG_USR   8'h02
`define FSCS_CFG_STO   8'h03
`define FSCS_I_DONE    0
`define FSCS_I_CMDERR  1
`define FSCS_I_AUTO    2
`define FSCS_I_REFUSE  3
`define FSCS_NINT      4
`define FSCS_NFLT      4
`define FSCS_WORDS     8
`define FSCS_FCNT_W    18
`define FSCS_WR_US     1400
`define FSCS_CLK_MHZ   100
`define FSCS_FW_DIV    7'd100
`define FSCS_DEF_CFG   32'h0000_1000
`endif

// *** hdl/fscs_snap_if.sv ***
// link between the controller and the snapshot record storage
`timescale 1ns/1ps
interface fscs_snap_if;
  logic             refresh;
  logic             load;
  logic             save;
  fscs_pkg::fscs_rec_t  live;
  logic [2:0]       idx;
  fscs_pkg::fscs_word_t rdWord;
  modport ctrl  (output refresh, load, save, live, idx, input rdWord);
  modport store (input refresh, load, save, live, idx, output rdWord);
endinterface : fscs_snap_if

// *** hdl/fscs_snap_store.sv ***
// snapshot record in ram and its flash copy, one word per entry
`timescale 1ns/1ps
`include "fscs_regs.svh"
module fscs_snap_store (
  // clock and reset
  input wire logic   ref_clk,
  input wire logic   arst_n,
  // controller side
  fscs_snap_if.store sif
);
  import fscs_pkg::*;
  fscs_word_t ram_reg   [`FSCS_WORDS];
  fscs_word_t flash_reg [`FSCS_WORDS];

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  // per-word ram and flash update
  for (genvar gi = 0; gi < `FSCS_WORDS; gi++) begin : g_word
    always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
        ram_reg[gi] <= '0;
      end else if (sif.load) begin
        ram_reg[gi] <= flash_reg[gi];
      end else if (sif.refresh) begin
        ram_reg[gi] <= sif.live[gi*32 +: 32];
      end
    end
    always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
        flash_reg[gi] <= '0;
      end else if (sif.save) begin
        flash_reg[gi] <= ram_reg[gi];
      end
    end
  end

  // readout word chosen by bus address
  assign sif.rdWord = ram_reg[sif.idx];

  AST_LOAD_COPY: assert property (sif.load |=> ram_reg[7] == $past(flash_reg[7]))
    else $error("flash to ram copy lost");
  AST_REFRESH: assert property (sif.refresh && !sif.load |=> ram_reg[0] == $past(sif.live[31:0]))
    else $error("ram not refreshed");
  AST_HOLD: assert property (!sif.refresh && !sif.load |=> $stable(ram_reg[3]))
    else $error("ram changed while capture off");
endmodule : fscs_snap_store

// *** hdl/fscs_top.sv ***
// snapshot capture and reset-cleared configuration store with wishbone registers
//
// The placing of the registers and the Wishbone interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "fscs_regs.svh"
module fscs_top #(
  parameter int FLASH_WR_CYC = `FSCS_WR_US * `FSCS_CLK_MHZ
) (
  // clock and reset
  input wire logic                  ref_clk,
  input wire logic                  arst_n,
  // wishbone slave
  input wire logic                  wb_cyc_i,
  input wire logic                  wb_stb_i,
  input wire logic                  wb_we_i,
  input wire logic [7:0]            wb_adr_i,
  input wire logic [3:0]            wb_sel_i,
  input wire logic [31:0]           wb_dat_i,
  output logic [31:0]               wb_dat_o,
  output logic                      wb_ack_o,
  // firmware parameters and fault pins
  input wire fscs_pkg::fscs_rec_t   liveParams,
  input wire logic [`FSCS_NFLT-1:0] faultIn,
  // status outputs
  output logic                      outEnable,
  output logic                      captureOn,
  output logic                      flashBusy,
  output logic [31:0]               cfgLive,
  output logic                      irq
);
  import fscs_pkg::*;

  fscs_snap_if sif ();

  fscs_state_e             state_reg;
  logic                    ack_reg;
  logic [31:0]             dat_reg;
  logic                    outEn_reg;
  logic                    snapEn_reg;
  logic [`FSCS_NFLT-1:0]   fltCfg_reg;
  logic [`FSCS_NFLT-1:0]   fltS1_reg;
  logic [`FSCS_NFLT-1:0]   fltS2_reg;
  logic [`FSCS_NFLT-1:0]   fltS3_reg;
  logic [`FSCS_NINT-1:0]   intSt_reg;
  logic [`FSCS_NINT-1:0]   intSt_next;
  logic [`FSCS_NINT-1:0]   intMsk_reg;
  logic                    irq_reg;
  logic [31:0]             cfgLive_reg;
  logic [31:0]             userStore_reg;
  logic                    userValid_reg;
  logic [6:0]              fwCnt_reg;
  logic                    fwTick_reg;
  logic                    busy;
  logic                    done;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  // bus request decode
  wire       wbReq   = wb_cyc_i && wb_stb_i && !ack_reg;
  wire       wbWr    = wbReq && wb_we_i && wb_sel_i[0];
  wire       wbRd    = wbReq && !wb_we_i;
  wire [7:0] wrByte  = wb_dat_i[7:0];
  wire       hitOpt  = wb_adr_i == `FSCS_A_OPTIONS;
  wire       hitOper = wb_adr_i == `FSCS_A_OPER;
  wire       hitSnap = wb_adr_i == `FSCS_A_SNAPCMD;
  wire       hitStat = wb_adr_i == `FSCS_A_STATUS;
  wire       hitIst  = wb_adr_i == `FSCS_A_INTST;
  wire       hitImsk = wb_adr_i == `FSCS_A_INTMSK;
  wire       hitFlt  = wb_adr_i == `FSCS_A_FLTCFG;
  wire       hitCfg  = wb_adr_i == `FSCS_A_CFGCMD;
  wire       hitLive = wb_adr_i == `FSCS_A_CFGLIVE;
  // snapshot window: eight words after its base
  wire       hitRec  = (wb_adr_i[7:5] == `FSCS_SNAP_WIN) && (wb_adr_i[1:0] == 2'h0);

  // snapshot commands
  wire snapWr   = wbWr && hitSnap;
  wire isLoad   = wrByte == `FSCS_CMD_LOAD;
  wire isSave   = wrByte == `FSCS_CMD_SAVE;
  wire loadCmd  = snapWr && isLoad && !busy;
  wire saveCmd  = snapWr && isSave && !outEn_reg && !busy;
  wire cmdErr   = snapWr && !loadCmd && !saveCmd;

  // fault edges after the synchroniser
  wire [`FSCS_NFLT-1:0] fltEdge = fltS2_reg & ~fltS3_reg;
  wire faultShut = |(fltEdge & fltCfg_reg);
  wire autoSave  = faultShut && !busy && !saveCmd;
  wire saveReq   = saveCmd || autoSave;

  // configuration store commands
  wire cfgWr     = wbWr && hitCfg && state_reg == ST_RUN;
  wire rstDef    = cfgWr && wrByte == `FSCS_CFG_DEF;
  wire rstUsr    = cfgWr && wrByte == `FSCS_CFG_USR;
  wire stoUsr    = cfgWr && wrByte == `FSCS_CFG_STO;
  wire refuse    = cfgWr && !rstDef && !stoUsr && !(rstUsr && userValid_reg);

  // interrupt events and write-one clear
  wire [`FSCS_NINT-1:0] intEv  = {refuse, autoSave, cmdErr, done};
  wire [`FSCS_NINT-1:0] intClr = (wbWr && hitIst) ? wb_dat_i[`FSCS_NINT-1:0] : '0;
  // set wins over a clear in the same cycle
  assign intSt_next = (intSt_reg & ~intClr) | intEv;

  // read data selection
  wire [31:0] statWord = {28'h0, userValid_reg, fwTick_reg, busy, outEn_reg};
  wire [31:0] rdMux =
    hitOpt  ? {30'h0, snapEn_reg, 1'b0} :
    hitOper ? {31'h0, outEn_reg} :
    hitStat ? statWord :
    hitIst  ? {28'h0, intSt_reg} :
    hitImsk ? {28'h0, intMsk_reg} :
    hitFlt  ? {28'h0, fltCfg_reg} :
    hitLive ? cfgLive_reg :
    hitRec  ? sif.rdWord : 32'h0;

  // record storage wiring
  assign sif.live    = liveParams;
  assign sif.idx     = wb_adr_i[4:2];
  assign sif.load    = loadCmd;
  assign sif.save    = saveReq;
  // refresh only while capture is on
  assign sif.refresh = fwTick_reg && snapEn_reg;

  // wishbone answer one cycle after the request
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ack_reg <= 1'b0;
      dat_reg <= '0;
    end else begin
      ack_reg <= wbReq;
      dat_reg <= wbRd ? rdMux : 32'h0;
    end
  end

  // capture enable option
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      snapEn_reg <= 1'b0;
    end else if (wbWr && hitOpt) begin
      snapEn_reg <= wb_dat_i[`FSCS_B_SNAPEN];
    end
  end

  // module output enable, dropped by a shutdown fault
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      outEn_reg <= 1'b0;
    end else if (faultShut) begin
      outEn_reg <= 1'b0;
    end else if (wbWr && hitOper) begin
      outEn_reg <= wb_dat_i[`FSCS_B_OUTEN];
    end
  end

  // fault response configuration, one means shutdown
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      fltCfg_reg <= '0;
    end else if (wbWr && hitFlt) begin
      fltCfg_reg <= wb_dat_i[`FSCS_NFLT-1:0];
    end
  end

  // fault pin synchroniser and edge stage
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      fltS1_reg <= '0;
      fltS2_reg <= '0;
      fltS3_reg <= '0;
    end else begin
      fltS1_reg <= faultIn;
      fltS2_reg <= fltS1_reg;
      fltS3_reg <= fltS2_reg;
    end
  end

  // firmware cycle divider
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      fwCnt_reg  <= '0;
      fwTick_reg <= 1'b0;
    end else begin
      fwTick_reg <= fwCnt_reg == `FSCS_FW_DIV - 7'd1;
      fwCnt_reg  <= (fwCnt_reg == `FSCS_FW_DIV - 7'd1) ? '0 : fwCnt_reg + 7'd1;
    end
  end

  // initialization then run
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= ST_INIT;
    end else begin
      state_reg <= ST_RUN;
    end
  end

  // live configuration and the stores
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cfgLive_reg <= '0;
    end else if (state_reg == ST_INIT) begin
      cfgLive_reg <= userValid_reg ? userStore_reg : `FSCS_DEF_CFG;
    end else if (rstDef) begin
      cfgLive_reg <= `FSCS_DEF_CFG;
    end else if (rstUsr && userValid_reg) begin
      cfgLive_reg <= userStore_reg;
    end else if (wbWr && hitLive) begin
      cfgLive_reg <= wb_dat_i;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      userStore_reg <= '0;
      userValid_reg <= 1'b0;
    end else if (stoUsr) begin
      userStore_reg <= cfgLive_reg;
      userValid_reg <= 1'b1;
    end
  end

  // interrupt status, mask and line
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      intSt_reg  <= '0;
      intMsk_reg <= '0;
      irq_reg    <= 1'b0;
    end else begin
      intSt_reg <= intSt_next;
      irq_reg   <= |(intSt_next & intMsk_reg);
      if (wbWr && hitImsk) begin
        intMsk_reg <= wb_dat_i[`FSCS_NINT-1:0];
      end
    end
  end

  // flash write busy interval
  fscs_flash_timer #(
    .CYC (FLASH_WR_CYC)
  ) u_timer (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .start   (saveReq),
    .busy    (busy),
    .done    (done)
  );

  // snapshot record storage
  fscs_snap_store u_store (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .sif     (sif)
  );

  // outputs straight from flops
  assign wb_dat_o  = dat_reg;
  assign wb_ack_o  = ack_reg;
  assign outEnable = outEn_reg;
  assign captureOn = snapEn_reg;
  assign flashBusy = busy;
  assign cfgLive   = cfgLive_reg;
  assign irq       = irq_reg;

  // checks
  sequence sWrOpt;
    wbWr && hitOpt;
  endsequence
  sequence sSaveWhileOn;
    snapWr && isSave && outEn_reg && !busy && !faultShut;
  endsequence
  sequence sAutoFault;
    faultShut && !busy && !saveCmd;
  endsequence
  sequence sLoadBusy;
    snapWr && isLoad && busy;
  endsequence
  sequence sCfgUnknown;
    cfgWr && !rstDef && !rstUsr && !stoUsr;
  endsequence

  // bus and capture checks
  AST_CAP_SET: assert property (sWrOpt |=> captureOn == $past(wb_dat_i[`FSCS_B_SNAPEN]))
    else $error("capture bit not taken");
  AST_REC_READ: assert property (wbRd && hitRec |=> wb_ack_o && wb_dat_o == $past(sif.rdWord))
    else $error("snapshot word not returned");
  AST_REFRESH_GATE: assert property (!snapEn_reg |-> !sif.refresh)
    else $error("ram refresh while capture off");

  // snapshot command checks
  AST_SAVE_OFF: assert property (saveCmd |=> flashBusy && !outEnable)
    else $error("save command not started");
  AST_SAVE_ON: assert property (sSaveWhileOn |=> !flashBusy ##0 intSt_reg[`FSCS_I_CMDERR])
    else $error("save while enabled not refused");
  AST_CMDERR_SET: assert property (cmdErr |=> intSt_reg[`FSCS_I_CMDERR])
    else $error("command error not flagged");
  AST_LOAD_BUSY: assert property (sLoadBusy |=> intSt_reg[`FSCS_I_CMDERR])
    else $error("load during flash write not refused");

  // fault checks
  AST_AUTO: assert property (faultShut && !busy |=> flashBusy ##0 !outEnable)
    else $error("shutdown fault not saved");
  AST_AUTO_FLAG: assert property (sAutoFault |=> intSt_reg[`FSCS_I_AUTO])
    else $error("auto save not flagged");
  AST_RETRY: assert property (!busy && !faultShut && !saveCmd |=> !flashBusy)
    else $error("flash write without cause");

  // configuration checks
  AST_INIT: assert property (state_reg == ST_INIT && !userValid_reg |=> cfgLive == `FSCS_DEF_CFG)
    else $error("default not loaded at init");
  AST_RECALL: assert property (rstDef |=> cfgLive == `FSCS_DEF_CFG)
    else $error("default recall failed");
  AST_REFUSE: assert property (rstUsr && !userValid_reg |=> $stable(cfgLive) ##0 intSt_reg[`FSCS_I_REFUSE])
    else $error("restore of absent level taken");
  AST_UNKNOWN_CFG: assert property (sCfgUnknown |=> $stable(cfgLive) ##0 intSt_reg[`FSCS_I_REFUSE])
    else $error("unknown restore level taken");
  AST_USER: assert property (stoUsr |=> userValid_reg ##1 $stable(userStore_reg))
    else $error("user store not kept");
endmodule : fscs_top

// *** verif/fscs_param_src.sv ***
// firmware side model: live parameter record and fault pins
`timescale 1ns/1ps
module fscs_param_src (
  // clock and reset
  input wire logic             ref_clk,
  input wire logic             arst_n,
  // bench control
  input wire logic [31:0]      seed,
  input wire logic [3:0]       faultReq,
  // toward the block
  output fscs_pkg::fscs_rec_t  liveParams,
  output logic [3:0]           faultIn
);
  import fscs_pkg::*;
  // word k carries seed plus k, fault pins follow the bench a cycle later
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      liveParams <= '0;
      faultIn    <= 4'h0;
    end else begin
      for (int k = 0; k < 8; k++) begin
        liveParams[32*k +: 32] <= seed + 32'(k);
      end
      faultIn <= faultReq;
    end
  end
endmodule : fscs_param_src

// *** verif/tb.sv ***
// self-checking bench of the snapshot capture store
`timescale 1ns/1ps
`include "fscs_regs.svh"
module tb;
  import fscs_pkg::*;
  localparam int FWC = 20;
  logic        ref_clk;
  logic        arst_n;
  logic        wbCyc;
  logic        wbStb;
  logic        wbWe;
  logic [7:0]  wbAdr;
  logic [3:0]  wbSel;
  logic [31:0] wbDat;
  logic [31:0] wbDatO;
  logic        wbAck;
  fscs_rec_t   liveParams;
  logic [3:0]  faultIn;
  logic [3:0]  faultReq;
  logic [31:0] seed;
  logic [31:0] cfgLive;
  logic        outEnable;
  logic        captureOn;
  logic        flashBusy;
  logic        irq;
  logic [31:0] rd;
  int          n_mismatch;
  int          check_count;
  int          cycles;

  fscs_top #(.FLASH_WR_CYC(FWC)) dut_u (
    .ref_clk(ref_clk), .arst_n(arst_n), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
    .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDat), .wb_dat_o(wbDatO), .wb_ack_o(wbAck),
    .liveParams(liveParams), .faultIn(faultIn), .outEnable(outEnable), .captureOn(captureOn),
    .flashBusy(flashBusy), .cfgLive(cfgLive), .irq(irq));
  fscs_param_src src_u (.ref_clk(ref_clk), .arst_n(arst_n), .seed(seed), .faultReq(faultReq),
    .liveParams(liveParams), .faultIn(faultIn));

  // clock generation
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task give_verdict;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : give_verdict

  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // one classic cycle, held until ack is sampled
  task xfer(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe  <= we;
    wbAdr <= a;
    wbDat <= d;
    do begin
      @(posedge ref_clk);
      n++;
    end while (wbAck !== 1'b1 && n < 50);
    rd = wbDatO;
    if (n >= 50) chk("wbAck", 32'h1, 32'h0);
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe  <= 1'b0;
    @(posedge ref_clk);
  endtask : xfer

  task wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr

  task rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(name, exp, rd);
  endtask : rdchk

  task waitc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : waitc

  task snapchk(input logic [31:0] s);
    for (int k = 0; k < 8; k++) begin
      rdchk("snapWord", 8'h40 + 8'(4 * k), s + 32'(k));
    end
  endtask : snapchk

  task t_reset;
    chk("cfgLivePort", `FSCS_DEF_CFG, cfgLive);
    rdchk("cfgLive", `FSCS_A_CFGLIVE, `FSCS_DEF_CFG);
    wr(8'hF0, 32'hFFFF_FFFF);
    rdchk("unmapped", 8'hF0, 32'h0);
  endtask : t_reset

  task t_capture;
    seed <= 32'hA000_0000;
    wr(`FSCS_A_OPTIONS, 32'h2);
    chk("captureOn", 32'h1, 32'(captureOn));
    rdchk("options", `FSCS_A_OPTIONS, 32'h2);
    waitc(250);
    snapchk(32'hA000_0000);
    wr(`FSCS_A_OPTIONS, 32'h0);
    chk("captureOn", 32'h0, 32'(captureOn));
    seed <= 32'hB000_0000;
    waitc(250);
    snapchk(32'hA000_0000);
  endtask : t_capture

  task t_save;
    int n;
    n = 0;
    wr(`FSCS_A_INTMSK, 32'h2);
    wr(`FSCS_A_OPER, 32'h1);
    wr(`FSCS_A_SNAPCMD, 32'h2);
    waitc(3);
    chk("flashBusy", 32'h0, 32'(flashBusy));
    rdchk("intSt", `FSCS_A_INTST, 32'h2);
    chk("irq", 32'h1, 32'(irq));
    wr(`FSCS_A_INTST, 32'h2);
    waitc(2);
    chk("irq", 32'h0, 32'(irq));
    wr(`FSCS_A_OPER, 32'h0);
    wr(`FSCS_A_SNAPCMD, 32'h2);
    xfer(1'b0, `FSCS_A_STATUS, 32'h0);
    chk("status", 32'h2, rd & 32'hB);
    repeat (FWC + 40) begin
      @(posedge ref_clk);
      if (flashBusy === 1'b1) n++;
    end
    chk("busyLen", 32'h1, 32'(n > 0 && n <= FWC));
    rdchk("intSt", `FSCS_A_INTST, 32'h1);
    wr(`FSCS_A_INTST, 32'hF);
  endtask : t_save

  task t_load;
    seed <= 32'hC000_0000;
    wr(`FSCS_A_OPTIONS, 32'h2);
    waitc(250);
    wr(`FSCS_A_OPTIONS, 32'h0);
    snapchk(32'hC000_0000);
    wr(`FSCS_A_SNAPCMD, 32'h1);
    snapchk(32'hA000_0000);
  endtask : t_load

  task t_fault;
    wr(`FSCS_A_FLTCFG, 32'h1);
    wr(`FSCS_A_INTMSK, 32'h4);
    wr(`FSCS_A_OPER, 32'h1);
    wr(`FSCS_A_OPTIONS, 32'h2);
    faultReq <= 4'h1;
    waitc(8);
    chk("outEnable", 32'h0, 32'(outEnable));
    chk("flashBusy", 32'h1, 32'(flashBusy));
    chk("irq", 32'h1, 32'(irq));
    faultReq <= 4'h0;
    waitc(FWC + 10);
    wr(`FSCS_A_INTST, 32'hF);
    wr(`FSCS_A_FLTCFG, 32'h0);
    wr(`FSCS_A_OPER, 32'h1);
    faultReq <= 4'h2;
    waitc(30);
    chk("outEnable", 32'h1, 32'(outEnable));
    chk("flashBusy", 32'h0, 32'(flashBusy));
    rdchk("intSt", `FSCS_A_INTST, 32'h0);
    faultReq <= 4'h0;
    wr(`FSCS_A_OPTIONS, 32'h0);
  endtask : t_fault

  task t_cfg;
    wr(`FSCS_A_CFGLIVE, 32'h0000_5A5A);
    wr(`FSCS_A_CFGCMD, `FSCS_CFG_USR);
    rdchk("intSt", `FSCS_A_INTST, 32'h8);
    chk("cfgLive", 32'h0000_5A5A, cfgLive);
    wr(`FSCS_A_INTST, 32'h8);
    wr(`FSCS_A_CFGCMD, 32'h5);
    rdchk("intSt", `FSCS_A_INTST, 32'h8);
    wr(`FSCS_A_CFGCMD, `FSCS_CFG_STO);
    wr(`FSCS_A_CFGLIVE, 32'h0000_00C3);
    wr(`FSCS_A_CFGCMD, `FSCS_CFG_DEF);
    chk("cfgLive", `FSCS_DEF_CFG, cfgLive);
    wr(`FSCS_A_CFGCMD, `FSCS_CFG_USR);
    chk("cfgLive", 32'h0000_5A5A, cfgLive);
  endtask : t_cfg

  // hang guard
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  // main sequence
  initial begin
    n_mismatch = 0;
    check_count = 0;
    cycles = 0;
    arst_n = 1'b0;
    wbCyc = 1'b0;
    wbStb = 1'b0;
    wbWe = 1'b0;
    wbAdr = 8'h00;
    wbSel = 4'hF;
    wbDat = 32'h0;
    seed = 32'h0;
    faultReq = 4'h0;
    repeat (12) @(posedge ref_clk);
    arst_n <= 1'b1;
    waitc(3);
    t_reset();
    t_capture();
    t_save();
    t_load();
    t_fault();
    t_cfg();
    give_verdict();
  end
endmodule : tb
